/* xcr_xcvr_block.sv */
/*
  Digital model of one four-channel transceiver block in XAUI mode: transmit
  PLL clock enable, lock indications, resets, transmit phase FIFO, word aligner.
  Assumes the line model delivers raw 10-bit words on core_clk with a valid pulse.
*/
// Implementation choices: the APB register port and the address map.
`timescale 1ns/10ps
`include "xcr_cfg.svh"
module xcr_xcvr_block #(
  parameter int NCH        = `XCR_BLOCK_CH,
  parameter int PLL_DIV    = `XCR_PLL_DIV,
  parameter int LOCK_CNT   = `XCR_LOCK_CNT,
  parameter int FIFO_DEPTH = `XCR_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  // Fabric side.
  xcr_fabric_if.dev                     fab,
  // Line side.
  input  wire logic [NCH*`XCR_SYM_W-1:0] line_rx_word,
  input  wire logic [NCH-1:0]           line_rx_valid,
  output logic [NCH*16-1:0]             line_tx_word,
  output logic                          line_tx_valid
);
  localparam int SW = `XCR_SYM_W;
  localparam int BW = `XCR_BYTE_W;
  localparam int DW = 2 * BW;
  localparam int DVW = (PLL_DIV > 1) ? $clog2(PLL_DIV) : 1;
  localparam int LKW = $clog2(LOCK_CNT + 1);
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  if (NCH != `XCR_BLOCK_CH) begin : g_chk_nch
    $error("A block carries exactly four duplex channels.");
  end
  if (PLL_DIV < 2 || LOCK_CNT < 1) begin : g_chk_cnt
    $error("Divider must be at least 2 and lock count at least 1.");
  end
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk_fifo
    $error("FIFO depth must be a power of two of at least 2.");
  end

  function automatic logic is_comma(input logic [SW-1:0] w);
    is_comma = (w == `XCR_K285_NEG) || (w == `XCR_K285_POS);
  endfunction

  function automatic logic [SW-1:0] window(input logic [2*SW-1:0] cat,
                                           input logic [3:0] off);
    logic [2*SW-1:0] sh;
    sh = cat >> off;
    window = sh[SW-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Block reset, transmit PLL clock enable and lock.

  wire blk_rst = sys_rst | fab.pll_reset | ~fab.pll_enable;
  // The inter-block line two does not reach the transmit PLL, so it stays idle.
  wire pll_ref_ok = fab.refclk_src != xcr_pkg::xcr_ref_inter_block_clock_line_2;
  wire pll_run = ~blk_rst & pll_ref_ok;

  logic [DVW-1:0] div_cnt;
  logic           pll_en;
  logic [LKW-1:0] tx_lock_cnt;
  wire div_wrap = div_cnt == DVW'(PLL_DIV - 1);

  always_ff @(posedge core_clk) begin
    if (!pll_run) begin
      div_cnt <= '0;
      pll_en  <= 1'b0;
    end else begin
      div_cnt <= div_wrap ? '0 : div_cnt + 1'b1;
      pll_en  <= div_wrap;
    end
  end

  wire tx_locked = tx_lock_cnt == LKW'(LOCK_CNT);
  always_ff @(posedge core_clk) begin
    if (!pll_run) begin
      tx_lock_cnt <= '0;
    end else if (pll_en && !tx_locked) begin
      tx_lock_cnt <= tx_lock_cnt + 1'b1;
    end
  end

  assign fab.core_clk_en   = pll_en;
  assign fab.tx_pll_locked = tx_locked;
  // The detector is forced on, so line activity never reaches this output.
  assign fab.rx_signal_detect = '1;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      line_tx_valid <= 1'b0;
    end else begin
      line_tx_valid <= pll_en;
    end
  end

  // The write side follows the fabric enable only when chosen.
  wire wr_tick = fab.ext_wr_clk_sel ? fab.tx_wr_en : pll_en;

  ////////////////////////////////////////////////////////////////////////////
  // Channels.

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire rx_rst_d = blk_rst | fab.rx_digital_reset[c];
    wire tx_rst_d = blk_rst | fab.tx_digital_reset[c];
    wire rx_rst_a = blk_rst | fab.rx_analog_reset[c];

    // Receive PLL, trained by the transmit PLL.
    logic [LKW-1:0] rx_lock_cnt;
    wire rx_locked = rx_lock_cnt == LKW'(LOCK_CNT);
    always_ff @(posedge core_clk) begin
      if (rx_rst_a) begin
        rx_lock_cnt <= '0;
      end else if (pll_en && !rx_locked) begin
        rx_lock_cnt <= rx_lock_cnt + 1'b1;
      end
    end
    assign fab.rx_locked_n[c] = ~rx_locked;

    // Phase FIFO: pointers start half a depth apart and wrap freely, so a
    // rate mismatch silently repeats or drops words and nothing flags it.
    logic [DW-1:0] mem [FIFO_DEPTH];
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [DW-1:0] tx_q;
    always_ff @(posedge core_clk) begin
      if (tx_rst_d) begin
        wptr <= PW'(FIFO_DEPTH / 2);
        rptr <= '0;
        tx_q <= '0;
      end else begin
        if (wr_tick) begin
          mem[wptr] <= fab.tx_data[c*DW +: DW];
          wptr      <= wptr + 1'b1;
        end
        if (pll_en) begin
          rptr <= rptr + 1'b1;
          tx_q <= fab.width16 ? mem[rptr] : {{BW{1'b0}}, mem[rptr][BW-1:0]};
        end
      end
    end
    assign line_tx_word[c*DW +: DW] = tx_q;

    // Word aligner over the current and previous raw words.
    logic [SW-1:0] prev;
    logic [3:0]    off;
    logic          lane;
    logic [1:0]    sync_q;
    logic [1:0]    pat_q;
    logic          st_en;
    logic [2*SW-1:0] pair;
    logic [2*SW-1:0] rx_q;
    wire [SW-1:0]   cur = line_rx_word[c*SW +: SW];
    wire [2*SW-1:0] cat = {cur, prev};
    logic [3:0] hit_off;
    logic       any_hit;
    always_comb begin
      hit_off = '0;
      any_hit = 1'b0;
      for (int k = SW - 1; k >= 0; k--) begin
        if (is_comma(window(cat, 4'(k)))) begin
          hit_off = 4'(k);
          any_hit = 1'b1;
        end
      end
    end
    wire on_cur = is_comma(window(cat, off));
    wire moved = !on_cur && any_hit && hit_off != off;
    wire [3:0] next_off = moved ? hit_off : off;
    wire [SW-1:0] aligned = window(cat, next_off);
    wire [1:0] lane_sel = (fab.width16 && lane) ? 2'b10 : 2'b01;

    always_ff @(posedge core_clk) begin
      if (rx_rst_d) begin
        prev   <= '0;
        off    <= '0;
        lane   <= 1'b0;
        sync_q <= '0;
        pat_q  <= '0;
        st_en  <= 1'b0;
        pair   <= '0;
      end else begin
        st_en <= line_rx_valid[c];
        if (line_rx_valid[c]) begin
          prev   <= cur;
          off    <= next_off;
          lane   <= fab.width16 ? ~lane : 1'b0;
          // Both flags stand until the next recovered word replaces them.
          sync_q <= moved ? lane_sel : 2'b00;
          pat_q  <= on_cur ? lane_sel : 2'b00;
          if (lane_sel[1]) begin
            pair[2*SW-1:SW] <= aligned;
          end else begin
            pair[SW-1:0] <= aligned;
          end
        end
      end
    end

    always_ff @(posedge core_clk) begin
      if (rx_rst_d) begin
        rx_q <= '0;
      end else if (pll_en) begin
        rx_q <= fab.width16 ? pair : {{SW{1'b0}}, pair[SW-1:0]};
      end
    end
    assign fab.rx_data[c*2*SW +: 2*SW]   = rx_q;
    assign fab.rx_status_en[c]           = st_en;
    assign fab.rx_sync_status[c*2 +: 2]  = sync_q;
    assign fab.rx_pattern_found[c*2 +: 2] = pat_q;
  end
endmodule

/* xcr_cfg.svh */
/*
  Constants of the transceiver block model and of its fabric-side controller.
  Assumes it is included by bare name before any use of the macros.
*/
`ifndef XCR_CFG_SVH
`define XCR_CFG_SVH
`define XCR_BLOCK_CH      4
`define XCR_PLL_DIV       4
`define XCR_LOCK_CNT      64
`define XCR_FIFO_DEPTH    4
`define XCR_SYM_W         10
`define XCR_BYTE_W        8
`define XCR_K285_NEG      10'h0fa
`define XCR_K285_POS      10'h305
`define XCR_RATE_MBPS     3125
`define XCR_REF_MULT      20
`define XCR_ADDR_W        8
`define XCR_ADDR_CTRL     8'h00
`define XCR_ADDR_RST      8'h04
`define XCR_ADDR_STAT     8'h08
`define XCR_ADDR_CNT      8'h0c
`define XCR_CTRL_PLL_EN   0
`define XCR_CTRL_PLL_RST  1
`define XCR_CTRL_W16      2
`define XCR_CTRL_EXT_WR   3
`define XCR_CTRL_REF_LO   4
`define XCR_CTRL_W        6
`define XCR_CTRL_INIT     6'h02
`define XCR_RST_RXD_LO    0
`define XCR_RST_TXD_LO    4
`define XCR_RST_RXA_LO    8
`define XCR_RST_W         12
`define XCR_RST_INIT      12'hfff
`define XCR_STAT_SKEW     9
`define XCR_CNT_W         16
`endif

/* xcr_pkg.sv */
/*
  Types shared by both ends of the fabric link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package xcr_pkg;
  typedef enum logic [1:0] {
    xcr_ref_local = 2'b00,
    xcr_ref_line0 = 2'b01,
    xcr_ref_line1 = 2'b10,
    xcr_ref_inter_block_clock_line_2 = 2'b11
  } xcr_refsrc_t;
endpackage

/* xcr_fabric_if.sv */
/*
  Interface joining the transceiver block to the fabric logic.
  Assumes both ends run on core_clk; clocks are carried as enable pulses.
*/
`timescale 1ns/10ps
`include "xcr_cfg.svh"
interface xcr_fabric_if #(parameter int NCH = `XCR_BLOCK_CH);
  logic                      pll_enable;
  logic                      pll_reset;
  logic [NCH-1:0]            rx_digital_reset;
  logic [NCH-1:0]            tx_digital_reset;
  logic [NCH-1:0]            rx_analog_reset;
  logic                      width16;
  logic                      ext_wr_clk_sel;
  xcr_pkg::xcr_refsrc_t      refclk_src;
  logic                      tx_wr_en;
  logic [NCH*16-1:0]         tx_data;
  logic                      core_clk_en;
  logic                      tx_pll_locked;
  logic [NCH-1:0]            rx_locked_n;
  logic [NCH-1:0]            rx_signal_detect;
  logic [NCH*20-1:0]         rx_data;
  logic [NCH-1:0]            rx_status_en;
  logic [NCH*2-1:0]          rx_sync_status;
  logic [NCH*2-1:0]          rx_pattern_found;
  modport dev (
    input  pll_enable, pll_reset, rx_digital_reset, tx_digital_reset, rx_analog_reset,
    input  width16, ext_wr_clk_sel, refclk_src, tx_wr_en, tx_data,
    output core_clk_en, tx_pll_locked, rx_locked_n, rx_signal_detect, rx_data,
    output rx_status_en, rx_sync_status, rx_pattern_found
  );
  modport fab (
    output pll_enable, pll_reset, rx_digital_reset, tx_digital_reset, rx_analog_reset,
    output width16, ext_wr_clk_sel, refclk_src, tx_wr_en, tx_data,
    input  core_clk_en, tx_pll_locked, rx_locked_n, rx_signal_detect, rx_data,
    input  rx_status_en, rx_sync_status, rx_pattern_found
  );
endinterface

/* xcr_fabric_ctrl.sv */
/*
  Fabric-side controller of one transceiver block: APB registers that drive
  the block's resets and options, a transmit source, and receive status.
  Assumes an APB master on core_clk and the block on the other side of the link.
*/
`timescale 1ns/10ps
`include "xcr_cfg.svh"
module xcr_fabric_ctrl #(
  parameter int NCH         = `XCR_BLOCK_CH,
  parameter int REF_MULT    = `XCR_REF_MULT,
  parameter bit REF_DEDIC   = 1'b1,
  parameter bit RX_TRAINED  = 1'b1
) (
  // Clock and reset.
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  // Link to the block.
  xcr_fabric_if.fab                   fab,
  // APB slave.
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`XCR_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr
);
  if (NCH % 4 != 0 || NCH < 4) begin : g_chk_nch
    $error("Channel count must be a multiple of four.");
  end
  if (!(REF_MULT inside {2, 4, 5, 8, 10, 16, 20})) begin : g_chk_mult
    $error("Unsupported reference multiplication factor.");
  end
  if (REF_MULT <= 5 && (!REF_DEDIC || (REF_MULT == 2 && !RX_TRAINED))) begin : g_chk_ref
    $error("Low factors need dedicated pins; factor 2 needs training.");
  end

  logic [`XCR_CTRL_W-1:0] ctrl;
  logic [`XCR_RST_W-1:0]  rst;
  logic [`XCR_CNT_W-1:0]  sync_cnt;
  logic [`XCR_CNT_W-1:0]  pat_cnt;
  logic                   skew;
  logic [15:0]            tx_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  wire hit_ctrl = paddr == `XCR_ADDR_CTRL;
  wire hit_rst  = paddr == `XCR_ADDR_RST;
  wire hit_stat = paddr == `XCR_ADDR_STAT;
  wire hit_cnt  = paddr == `XCR_ADDR_CNT;
  wire hit_any  = hit_ctrl | hit_rst | hit_stat | hit_cnt;
  wire setup    = psel & ~penable;
  wire wr       = psel & penable & pwrite & hit_any;
  wire [1:0] wr_ref = pwdata[`XCR_CTRL_REF_LO +: 2];
  // Line two cannot feed the transmit PLL, so such a source is refused.
  wire ref_bad  = wr_ref == xcr_pkg::xcr_ref_inter_block_clock_line_2;

  wire [31:0] stat_word = {22'h000000, skew, fab.rx_signal_detect,
                           fab.rx_locked_n, fab.tx_pll_locked};
  wire [31:0] rd_mux = hit_ctrl ? {26'h0000000, ctrl} :
                       hit_rst  ? {20'h00000, rst} :
                       hit_stat ? stat_word :
                       hit_cnt  ? {pat_cnt, sync_cnt} : 32'h00000000;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= '0;
      ctrl   <= `XCR_CTRL_INIT;
      rst    <= `XCR_RST_INIT;
    end else begin
      if (setup) begin
        prdata <= rd_mux;
      end
      if (wr && hit_ctrl) begin
        ctrl[`XCR_CTRL_REF_LO-1:0] <= pwdata[`XCR_CTRL_REF_LO-1:0];
        if (!ref_bad) begin
          ctrl[`XCR_CTRL_REF_LO +: 2] <= wr_ref;
        end
      end
      if (wr && hit_rst) begin
        rst <= pwdata[`XCR_RST_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive the block.

  assign fab.pll_enable       = ctrl[`XCR_CTRL_PLL_EN];
  assign fab.pll_reset        = ctrl[`XCR_CTRL_PLL_RST];
  assign fab.width16          = ctrl[`XCR_CTRL_W16];
  assign fab.ext_wr_clk_sel   = ctrl[`XCR_CTRL_EXT_WR];
  assign fab.refclk_src       = xcr_pkg::xcr_refsrc_t'(ctrl[`XCR_CTRL_REF_LO +: 2]);
  assign fab.rx_digital_reset = rst[`XCR_RST_RXD_LO +: NCH];
  assign fab.tx_digital_reset = rst[`XCR_RST_TXD_LO +: NCH];
  assign fab.rx_analog_reset  = rst[`XCR_RST_RXA_LO +: NCH];
  // The external write enable is the block's own PLL enable looped back, so it
  // is locked in frequency; several blocks would share one active block's.
  assign fab.tx_wr_en         = fab.core_clk_en;
  assign fab.tx_data          = {NCH{tx_cnt}};

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_cnt <= '0;
    end else if (fab.tx_wr_en) begin
      tx_cnt <= tx_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive status. A comma seen on some lanes but not all in the same
  // recovered period marks skew that fabric deskew must remove.

  wire [NCH-1:0] lane_pat;
  wire [NCH-1:0] lane_sync;
  for (genvar c = 0; c < NCH; c++) begin : g_lane
    assign lane_pat[c]  = fab.rx_status_en[c] & |fab.rx_pattern_found[c*2 +: 2];
    assign lane_sync[c] = fab.rx_status_en[c] & |fab.rx_sync_status[c*2 +: 2];
  end
  wire skew_ev   = |lane_pat & ~&lane_pat;
  wire clr_skew  = wr & hit_stat & pwdata[`XCR_STAT_SKEW];
  wire clr_cnt   = wr & hit_cnt;
  wire sync_ev   = |lane_sync;
  wire pat_ev    = |lane_pat;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      skew     <= 1'b0;
      sync_cnt <= '0;
      pat_cnt  <= '0;
    end else begin
      skew     <= skew_ev | (skew & ~clr_skew);
      sync_cnt <= clr_cnt ? `XCR_CNT_W'(sync_ev) : sync_cnt + `XCR_CNT_W'(sync_ev);
      pat_cnt  <= clr_cnt ? `XCR_CNT_W'(pat_ev) : pat_cnt + `XCR_CNT_W'(pat_ev);
    end
  end
endmodule

/* xcr_link_properties.sv */
/*
  Checker of the fabric link between the transceiver block and its controller.
  Assumes the testbench feeds it the link signals by name, all on core_clk.
*/
`timescale 1ns/10ps
module xcr_link_properties #(
  parameter int NCH = 4
) (
  // Clock and reset.
  input wire logic             core_clk,
  input wire logic             sys_rst,
  // Controls from the fabric.
  input wire logic             pll_enable,
  input wire logic             pll_reset,
  input wire logic [NCH-1:0]   rx_digital_reset,
  input wire logic [NCH-1:0]   rx_analog_reset,
  // Indications from the block.
  input wire logic             core_clk_en,
  input wire logic             tx_pll_locked,
  input wire logic [NCH-1:0]   rx_locked_n,
  input wire logic [NCH-1:0]   rx_signal_detect,
  input wire logic [NCH-1:0]   rx_status_en,
  input wire logic [NCH*2-1:0] rx_sync_status,
  input wire logic [NCH*2-1:0] rx_pattern_found
);
  logic blk_rst;

  // Any of the three terms holds the whole block, so timing checks pause under it.
  assign blk_rst = sys_rst | pll_reset | ~pll_enable;

  //////////////////////////////////////////////////////////////////////////////
  sig_detect_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rx_signal_detect == '1) else $error("signal detect not asserted");
  enable_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!pll_enable) [*2] |-> !core_clk_en && !tx_pll_locked && rx_locked_n == '1)
    else $error("block runs while disabled");
  pll_reset_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    pll_reset [*2] |-> !core_clk_en && rx_status_en == '0 && rx_sync_status == '0)
    else $error("block runs under pll reset");
  tick_period_a: assert property (@(posedge core_clk) disable iff (blk_rst)
    core_clk_en |=> !core_clk_en [*3] ##1 core_clk_en) else $error("tick period wrong");
  lock_wait_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(rx_locked_n[0]) |-> $past(rx_analog_reset[0], 8) == 1'b0 && $past(blk_rst, 8) == 1'b0)
    else $error("receive lock too early");
  tx_lock_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(tx_pll_locked) |-> $past(blk_rst, 8) == 1'b0) else $error("transmit lock too early");
  analog_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rx_analog_reset[0] [*2] |-> rx_locked_n[0]) else $error("locked under analog reset");
  dig_reset_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rx_digital_reset[0] [*2] |-> !rx_status_en[0] && rx_sync_status[1:0] == 2'b00
    && rx_pattern_found[1:0] == 2'b00) else $error("status under digital reset");
  status_hold_a: assert property (@(posedge core_clk) disable iff (blk_rst)
    !rx_status_en[0] && !rx_digital_reset[0] && !$past(rx_digital_reset[0]) && !$past(blk_rst)
    |-> $stable(rx_sync_status[1:0]) && $stable(rx_pattern_found[1:0]))
    else $error("status changed without a word");
  move_only_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rx_sync_status[0] |-> !rx_pattern_found[0]) else $error("pattern on a boundary move");
endmodule

/* xaui_xcvr_clock_reset_status_tb.sv */
/*
  Testbench joining the block and its controller; drives APB and the line side.
  Assumes the small lock count of 4 ticks and a tick every 4 cycles.
*/
`timescale 1ns/10ps
module xaui_xcvr_clock_reset_status_tb;
  localparam int NCH = 4;
  localparam int DIV = 4;
  typedef struct {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wd;
    logic [31:0] exp;
    logic        err;
  } xcr_row_t;
  logic              core_clk;
  logic              sys_rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [NCH*10-1:0] line_rx_word;
  logic [NCH-1:0]    line_rx_valid;
  logic [NCH*16-1:0] line_tx_word;
  logic              line_tx_valid;
  logic [31:0]       rd;
  logic              err;
  int                n_errors;
  int                n_tests;
  int                cycles;
  int                n;
  xcr_row_t rows [10] = '{
    '{1'h0, 8'h00, 32'h0, 32'h2, 1'h0}, '{1'h0, 8'h04, 32'h0, 32'hfff, 1'h0},
    '{1'h0, 8'h08, 32'h0, 32'h1fe, 1'h0}, '{1'h0, 8'h0c, 32'h0, 32'h0, 1'h0},
    '{1'h0, 8'h10, 32'h0, 32'h0, 1'h1}, '{1'h1, 8'h10, 32'hff, 32'h0, 1'h1},
    '{1'h1, 8'h00, 32'h31, 32'h0, 1'h0}, '{1'h0, 8'h00, 32'h0, 32'h1, 1'h0},
    '{1'h1, 8'h04, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h04, 32'h0, 32'h0, 1'h0}};

  xcr_fabric_if #(.NCH(NCH)) link ();
  xcr_xcvr_block #(.NCH(NCH), .PLL_DIV(DIV), .LOCK_CNT(4), .FIFO_DEPTH(4)) i_xcr_xcvr_block (
    .core_clk(core_clk), .sys_rst(sys_rst), .fab(link), .line_rx_word(line_rx_word),
    .line_rx_valid(line_rx_valid), .line_tx_word(line_tx_word), .line_tx_valid(line_tx_valid));
  xcr_fabric_ctrl #(.NCH(NCH)) i_xcr_fabric_ctrl (
    .core_clk(core_clk), .sys_rst(sys_rst), .fab(link), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  xcr_link_properties #(.NCH(NCH)) i_xcr_link_properties (
    .core_clk(core_clk), .sys_rst(sys_rst), .pll_enable(link.pll_enable),
    .pll_reset(link.pll_reset), .rx_digital_reset(link.rx_digital_reset),
    .rx_analog_reset(link.rx_analog_reset), .core_clk_en(link.core_clk_en),
    .tx_pll_locked(link.tx_pll_locked), .rx_locked_n(link.rx_locked_n),
    .rx_signal_detect(link.rx_signal_detect), .rx_status_en(link.rx_status_en),
    .rx_sync_status(link.rx_sync_status), .rx_pattern_found(link.rx_pattern_found));

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // The whole run needs about 240 cycles; the ceiling leaves wide margin.
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // The word stays on the line for one cycle, then status is read two edges on.
  task automatic send(input logic [NCH-1:0] mask, input logic [9:0] w);
    @(posedge core_clk);
    line_rx_word <= {NCH{w}};
    line_rx_valid <= mask;
    @(posedge core_clk);
    line_rx_valid <= '0;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic wait_lock();
    repeat (60) begin
      apb(1'h0, 8'h08, 32'h0);
      if (rd === 32'h1e1) break;
    end
    check(rd, 32'h1e1);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    line_rx_word = '0;
    line_rx_valid = '0;
    n_errors = 0;
    n_tests = 0;
    cycles = 0;
    sys_rst = 1'b1;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wd);
      if (!rows[i].wr) check(rd, rows[i].exp);
      check({31'h0, err}, {31'h0, rows[i].err});
    end
    $display("register rows done");
    wait_lock();
    @(posedge core_clk iff line_tx_valid === 1'b1);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (line_tx_valid !== 1'b1 && n < 20);
    check(32'(n), 32'(DIV));
    check({24'h0, line_tx_word[15:8]}, 32'h0);
    // A frequency-locked write enable neither drops nor repeats a word, so each
    // tick's byte is one above the last.
    apb(1'h1, 8'h00, 32'h9);
    @(posedge core_clk iff line_tx_valid === 1'b1);
    rd = {24'h0, line_tx_word[7:0] + 8'h01};
    @(posedge core_clk iff line_tx_valid === 1'b1);
    check({24'h0, line_tx_word[7:0]}, rd);
    apb(1'h1, 8'h04, 32'h10);
    repeat (2) @(posedge core_clk);
    check({16'h0, line_tx_word[15:0]}, 32'h0);
    apb(1'h1, 8'h04, 32'h0);
    apb(1'h1, 8'h00, 32'h1);
    $display("transmit tick done");
    repeat (3) send(4'h1, 10'h0fa);
    check({28'h0, link.rx_sync_status[1:0], link.rx_pattern_found[1:0]}, 32'h1);
    repeat (2 * DIV) @(posedge core_clk);
    check({12'h0, link.rx_data[19:0]}, 32'h0fa);
    repeat (2) send(4'h1, 10'h305);
    check({28'h0, link.rx_sync_status[1:0], link.rx_pattern_found[1:0]}, 32'h1);
    send(4'h1, 10'h0);
    send(4'h1, 10'h3d0);
    send(4'h1, 10'h001);
    check({28'h0, link.rx_sync_status[1:0], link.rx_pattern_found[1:0]}, 32'h4);
    send(4'h1, 10'h0);
    check({28'h0, link.rx_sync_status[1:0], link.rx_pattern_found[1:0]}, 32'h0);
    send(4'h1, 10'h3d0);
    send(4'h1, 10'h001);
    check({28'h0, link.rx_sync_status[1:0], link.rx_pattern_found[1:0]}, 32'h1);
    $display("aligner done");
    apb(1'h1, 8'h04, 32'h1);
    send(4'h3, 10'h0);
    send(4'h3, 10'h3d0);
    send(4'h3, 10'h001);
    check({29'h0, link.rx_sync_status[2] | link.rx_pattern_found[2],
           link.rx_sync_status[0], link.rx_pattern_found[0]}, 32'h4);
    apb(1'h1, 8'h04, 32'h100);
    apb(1'h0, 8'h08, 32'h0);
    check(rd, 32'h3e3);
    apb(1'h1, 8'h04, 32'h0);
    // Two bytes per word: the high lane flags on the second word but takes the first, 0fa.
    apb(1'h1, 8'h00, 32'h5);
    send(4'h1, 10'h0fa);
    send(4'h1, 10'h305);
    check({28'h0, link.rx_sync_status[1:0], link.rx_pattern_found[1:0]}, 32'h2);
    send(4'h1, 10'h0);
    repeat (2 * DIV) @(posedge core_clk);
    check({12'h0, link.rx_data[19:0]}, 32'h3eb05);
    apb(1'h1, 8'h00, 32'h1);
    apb(1'h1, 8'h08, 32'h200);
    apb(1'h0, 8'h08, 32'h0);
    check(rd, 32'h1e1);
    apb(1'h0, 8'h0c, 32'h0);
    check(rd, 32'h00080002);
    apb(1'h1, 8'h0c, 32'h0);
    apb(1'h0, 8'h0c, 32'h0);
    check(rd, 32'h0);
    $display("channel resets done");
    apb(1'h1, 8'h00, 32'h3);
    apb(1'h0, 8'h08, 32'h0);
    check(rd, 32'h1fe);
    apb(1'h1, 8'h00, 32'h0);
    apb(1'h0, 8'h08, 32'h0);
    check(rd, 32'h1fe);
    apb(1'h1, 8'h00, 32'h1);
    wait_lock();
    $display("block resets done");
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    apb(1'h0, 8'h00, 32'h0);
    check(rd, 32'h2);
    apb(1'h0, 8'h08, 32'h0);
    check(rd, 32'h1fe);
    $display("mid-run reset done");
    conclude();
  end
endmodule
